// [logic/eip_controller.sv]
// external pin and pin-change interrupt controller with axi4-lite registers
`default_nettype none
`timescale 1ns/1ns
module eip_controller
   import eip_pkg::*;
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [EIP_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output var  logic                  s_axi_awready,
   input  wire logic [EIP_DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output var  logic                  s_axi_wready,
   output var  logic [1:0]            s_axi_bresp,
   output var  logic                  s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [EIP_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output var  logic                  s_axi_arready,
   output var  logic [EIP_DATA_W-1:0] s_axi_rdata,
   output var  logic [1:0]            s_axi_rresp,
   output var  logic                  s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  ext_request_pin_0,
   input  wire logic                  ext_request_pin_1,
   input  wire logic [EIP_NUM_PC-1:0] pin_change_inputs,
   input  wire logic                  io_clock_run,
   input  wire logic [1:0]            ext_ack,
   input  wire logic [2:0]            pc_ack,
   input  wire logic [1:0]            startup_time_select,
   input  wire logic [3:0]            clock_source_select,
   output var  logic [1:0]            ext_request,
   output var  logic                  pin_change_group0_request,
   output var  logic                  pin_change_group1_request,
   output var  logic                  pin_change_group2_request,
   output var  logic                  wake_request
);
   // pads are read regardless of pin direction
   logic [EIP_NUM_PINS-1:0] pins_stable;
   eip_pin_sync eip_pin_sync_i (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .pins_async  ({ext_request_pin_1, ext_request_pin_0,
                     pin_change_inputs}),
      .pins_stable (pins_stable)
   );

   logic [EIP_NUM_PC-1:0]  pc_stable;
   logic [EIP_NUM_EXT-1:0] ext_stable;
   assign pc_stable  = pins_stable[EIP_NUM_PC-1:0];
   assign ext_stable = pins_stable[EIP_NUM_PINS-1:EIP_NUM_PC];

   // registers
   logic [3:0]            sense_r;
   logic [1:0]            ext_en_r;
   logic [1:0]            ext_flag_r;
   logic [2:0]            pc_en_r;
   logic [2:0]            pc_flag_r;
   logic [7:0]            mask0_r;
   logic [6:0]            mask1_r;
   logic [7:0]            mask2_r;
   logic [EIP_NUM_PC-1:0] pc_prev_r;
   logic [1:0]            ext_prev_r;
   logic                  io_run_prev_r;
   logic [1:0]            start_sel_r;
   logic [3:0]            clk_src_r;
   logic                  cfg_done_r;
   logic [15:0]           start_cnt_r;
   eip_state_type         st_r;

   // bus state
   logic                  aw_have_r;
   logic                  w_have_r;
   logic [EIP_ADDR_W-1:0] awaddr_r;
   logic [EIP_DATA_W-1:0] wdata_r;
   logic [3:0]            wstrb_r;

   // write channel
   logic aw_take;
   logic w_take;
   logic wr_fire;
   logic aw_have_nxt;
   logic w_have_nxt;
   logic bvalid_nxt;
   assign aw_take     = s_axi_awvalid & s_axi_awready;
   assign w_take      = s_axi_wvalid & s_axi_wready;
   assign wr_fire     = aw_have_r & w_have_r & ~s_axi_bvalid;
   assign aw_have_nxt = (aw_have_r & ~wr_fire) | aw_take;
   assign w_have_nxt  = (w_have_r & ~wr_fire) | w_take;
   assign bvalid_nxt  = (s_axi_bvalid & ~s_axi_bready) | wr_fire;

   logic       wr_lane;
   logic       wr_sense;
   logic       wr_ext_en;
   logic       wr_ext_flag;
   logic       wr_pc_en;
   logic       wr_pc_flag;
   logic       wr_mask0;
   logic       wr_mask1;
   logic       wr_mask2;
   logic       wr_mapped;
   logic [7:0] wbyte;
   assign wr_lane     = wr_fire & wstrb_r[0];
   assign wbyte       = wdata_r[7:0];
   assign wr_sense    = wr_lane & (awaddr_r == ADDR_SENSE);
   assign wr_ext_en   = wr_lane & (awaddr_r == ADDR_EXT_EN);
   assign wr_ext_flag = wr_lane & (awaddr_r == ADDR_EXT_FLAG);
   assign wr_pc_en    = wr_lane & (awaddr_r == ADDR_PC_EN);
   assign wr_pc_flag  = wr_lane & (awaddr_r == ADDR_PC_FLAG);
   assign wr_mask0    = wr_lane & (awaddr_r == ADDR_MASK0);
   assign wr_mask1    = wr_lane & (awaddr_r == ADDR_MASK1);
   assign wr_mask2    = wr_lane & (awaddr_r == ADDR_MASK2);
   assign wr_mapped   = (awaddr_r <= ADDR_BOOT_CFG) & (awaddr_r[1:0] == 2'h0);

   // read channel
   logic ar_take;
   logic rvalid_nxt;
   assign ar_take    = s_axi_arvalid & s_axi_arready;
   assign rvalid_nxt = (s_axi_rvalid & ~s_axi_rready) | ar_take;

   logic                  st_run;
   logic                  st_start;
   assign st_run   = (st_r == ST_RUN);
   assign st_start = (st_r == ST_START);

   logic [EIP_DATA_W-1:0] rd_word;
   logic                  rd_mapped;
   assign rd_mapped = (s_axi_araddr <= ADDR_BOOT_CFG) &
                      (s_axi_araddr[1:0] == 2'h0);
   assign rd_word =
      (s_axi_araddr == ADDR_SENSE)    ? {28'h0000000, sense_r}    :
      (s_axi_araddr == ADDR_EXT_EN)   ? {30'h00000000, ext_en_r}  :
      (s_axi_araddr == ADDR_EXT_FLAG) ? {30'h00000000, ext_flag_r} :
      (s_axi_araddr == ADDR_PC_EN)    ? {29'h00000000, pc_en_r}   :
      (s_axi_araddr == ADDR_PC_FLAG)  ? {29'h00000000, pc_flag_r} :
      (s_axi_araddr == ADDR_MASK0)    ? {24'h000000, mask0_r}     :
      (s_axi_araddr == ADDR_MASK1)    ? {25'h0000000, mask1_r}    :
      (s_axi_araddr == ADDR_MASK2)    ? {24'h000000, mask2_r}     :
      (s_axi_araddr == ADDR_STATUS)   ?
         {28'h0000000, wake_request, st_start, ext_stable}        :
      (s_axi_araddr == ADDR_PC_LEVEL) ? {8'h00, pc_stable}        :
      (s_axi_araddr == ADDR_BOOT_CFG) ?
         {26'h0000000, start_sel_r, clk_src_r}                    :
                                        32'h00000000;

   // pin-change groups, always sampled on the always-on clock
   logic [EIP_NUM_PC-1:0] pc_chg;
   logic [2:0]            pc_set;
   logic [2:0]            pc_clr;
   logic [2:0]            pc_flag_nxt;
   assign pc_chg      = pc_stable ^ pc_prev_r;
   assign pc_set[0]   = |(pc_chg[7:0] & mask0_r);
   assign pc_set[1]   = |(pc_chg[14:8] & mask1_r);
   assign pc_set[2]   = |(pc_chg[23:16] & mask2_r);
   assign pc_clr      = ({3{wr_pc_flag}} & wbyte[2:0]) | pc_ack;
   assign pc_flag_nxt = pc_set | (pc_flag_r & ~pc_clr);

   // dedicated pins
   logic [1:0] ext_set;
   logic [1:0] ext_level_mode;
   logic [1:0] ext_low_req;
   logic [1:0] ext_clr;
   logic [1:0] ext_flag_nxt;
   logic [1:0] ext_req_nxt;
   genvar i;
   generate
      for (i = 0; i < EIP_NUM_EXT; i = i + 1) begin : g_ext
         logic [1:0] mode;
         logic       moved;
         assign mode  = sense_r[2*i +: 2];
         assign moved = io_clock_run &
                        (ext_stable[i] ^ ext_prev_r[i]);
         assign ext_set[i] = moved & ((mode == SENSE_ANY) |
            ((mode == SENSE_FALL) & ~ext_stable[i]) |
            ((mode == SENSE_RISE) & ext_stable[i]));
         assign ext_level_mode[i] = (mode == SENSE_LOW);
         assign ext_low_req[i] = ext_level_mode[i] &
                                 ~ext_stable[i];
      end
   endgenerate
   assign ext_clr      = ({2{wr_ext_flag}} & wbyte[1:0]) | ext_ack;
   assign ext_flag_nxt = ~ext_level_mode &
                         (ext_set | (ext_flag_r & ~ext_clr));
   // level requests are held off until start-up has run out
   assign ext_req_nxt  = ext_en_r & ((ext_low_req & {2{st_run}}) |
                                     ext_flag_r);

   logic wake_nxt;
   assign wake_nxt = ~io_clock_run & ((|(ext_en_r & ext_low_req)) |
                     (|(ext_en_r & ext_flag_r)) |
                     (|(pc_en_r & pc_flag_r)));

   // start-up length from the boot settings
   logic [15:0] start_cyc;
   logic        woke;
   assign start_cyc = 16'(((16'(clk_src_r) + CNT_ONE) * STARTUP_UNIT_CYC)
                          << start_sel_r);
   assign woke = io_clock_run & ~io_run_prev_r;

   eip_state_type st_nxt;
   logic [15:0]   start_cnt_nxt;
   always_comb begin
      st_nxt        = st_r;
      start_cnt_nxt = start_cnt_r;
      case (st_r)
         ST_RUN: begin
            if (woke) begin
               st_nxt        = ST_START;
               start_cnt_nxt = start_cyc;
            end
         end
         ST_START: begin
            if (start_cnt_r <= CNT_ONE) begin
               st_nxt = ST_RUN;
            end
            start_cnt_nxt = start_cnt_r - CNT_ONE;
         end
         default: begin
            st_nxt = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= RESP_OKAY;
         s_axi_rdata   <= 32'h00000000;
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         awaddr_r      <= 8'h00;
         wdata_r       <= 32'h00000000;
         wstrb_r       <= 4'h0;
      end else begin
         aw_have_r     <= aw_have_nxt;
         w_have_r      <= w_have_nxt;
         s_axi_bvalid  <= bvalid_nxt;
         s_axi_awready <= ~aw_have_nxt & ~bvalid_nxt;
         s_axi_wready  <= ~w_have_nxt & ~bvalid_nxt;
         s_axi_rvalid  <= rvalid_nxt;
         s_axi_arready <= ~rvalid_nxt;
         if (aw_take) begin
            awaddr_r <= s_axi_awaddr;
         end
         if (w_take) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end
         if (ar_take) begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sense_r  <= 4'h0;
         ext_en_r <= 2'h0;
         pc_en_r  <= 3'h0;
         mask0_r  <= 8'h00;
         mask1_r  <= 7'h00;
         mask2_r  <= 8'h00;
      end else begin
         if (wr_sense)  sense_r  <= wbyte[3:0];
         if (wr_ext_en) ext_en_r <= wbyte[1:0];
         if (wr_pc_en)  pc_en_r  <= wbyte[2:0];
         if (wr_mask0)  mask0_r  <= wbyte;
         if (wr_mask1)  mask1_r  <= wbyte[6:0];
         if (wr_mask2)  mask2_r  <= wbyte;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_flag_r    <= 2'h0;
         pc_flag_r     <= 3'h0;
         pc_prev_r     <= {EIP_NUM_PC{1'b1}};
         ext_prev_r    <= 2'h3;
         io_run_prev_r <= 1'b1;
         st_r          <= ST_RUN;
         start_cnt_r   <= 16'h0000;
         ext_request   <= 2'h0;
         pin_change_group0_request <= 1'b0;
         pin_change_group1_request <= 1'b0;
         pin_change_group2_request <= 1'b0;
         wake_request  <= 1'b0;
      end else begin
         ext_flag_r    <= ext_flag_nxt;
         pc_flag_r     <= pc_flag_nxt;
         pc_prev_r     <= pc_stable;
         // previous sample frozen while the io clock is halted
         if (io_clock_run) ext_prev_r <= ext_stable;
         io_run_prev_r <= io_clock_run;
         st_r          <= st_nxt;
         start_cnt_r   <= start_cnt_nxt;
         ext_request   <= ext_req_nxt;
         pin_change_group0_request <= pc_en_r[0] & pc_flag_r[0];
         pin_change_group1_request <= pc_en_r[1] & pc_flag_r[1];
         pin_change_group2_request <= pc_en_r[2] & pc_flag_r[2];
         wake_request  <= wake_nxt;
      end
   end

   // boot settings caught once after reset release
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         start_sel_r <= 2'h0;
         clk_src_r   <= 4'h0;
         cfg_done_r  <= 1'b0;
      end else if (!cfg_done_r) begin
         start_sel_r <= startup_time_select;
         clk_src_r   <= clock_source_select;
         cfg_done_r <= 1'b1;
      end
   end

   chk_group0_flag_set: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (|(pc_chg[7:0] & mask0_r)) |=> pc_flag_r[0])
      else $error("group0 masked change did not set flag");
   chk_group1_flag_set: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (|(pc_chg[14:8] & mask1_r)) |=> pc_flag_r[1])
      else $error("group1 masked change did not set flag");
   chk_group2_req_path: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ((|(pc_chg[23:16] & mask2_r)) && pc_en_r[2] && pc_ack[2] == 1'b0)
      |=> ##1 pin_change_group2_request)
      else $error("group2 change did not reach request");
   chk_mask_blocks_change: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!(|(pc_chg[7:0] & mask0_r)) && !pc_flag_r[0]) |=> !pc_flag_r[0])
      else $error("unmasked pin set group0 flag");
   chk_level_keeps_req: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (ext_en_r[0] && sense_r[1:0] == SENSE_LOW && !ext_stable[0] && st_run)
      |=> ext_request[0])
      else $error("level request missing while pin low");
   chk_edge_stall_halt: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !io_clock_run |=> ($stable(ext_prev_r) && $past(ext_set) == 2'h0))
      else $error("edge logic moved with io clock halted");
   chk_level_flag_clear: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (sense_r[3:2] == SENSE_LOW) |=> !ext_flag_r[1])
      else $error("flag set in level mode");
   chk_fall_edge_flag: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (sense_r[1:0] == SENSE_FALL && io_clock_run && ext_prev_r[0]
       && !ext_stable[0]) |=> ext_flag_r[0])
      else $error("falling edge did not set flag");
   chk_startup_holds_lvl: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (st_start && sense_r[1:0] == SENSE_LOW && !ext_flag_r[0])
      |=> !ext_request[0])
      else $error("level request during start-up");
   chk_sleep_level_wake: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!io_clock_run && ext_en_r[0] && sense_r[1:0] == SENSE_LOW
       && !ext_stable[0]) |=> wake_request)
      else $error("low level did not wake");
endmodule : eip_controller
`default_nettype wire

// [logic/eip_pin_sync.sv]
// three-stage input synchronizer with agreement filter
`default_nettype none
`timescale 1ns/1ns
module eip_pin_sync
   import eip_pkg::*;
(
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic [EIP_NUM_PINS-1:0] pins_async,
   output var  logic [EIP_NUM_PINS-1:0] pins_stable
);
   logic [EIP_NUM_PINS-1:0] s1_r;
   logic [EIP_NUM_PINS-1:0] s2_r;
   logic [EIP_NUM_PINS-1:0] s3_r;

   genvar i;
   generate
      for (i = 0; i < EIP_NUM_PINS; i = i + 1) begin : g_bit
         // stable level moves only once stages two and three agree
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               s1_r[i]        <= 1'b1;
               s2_r[i]        <= 1'b1;
               s3_r[i]        <= 1'b1;
               pins_stable[i] <= 1'b1;
            end else begin
               s1_r[i] <= pins_async[i];
               s2_r[i] <= s1_r[i];
               s3_r[i] <= s2_r[i];
               if (s2_r[i] == s3_r[i]) begin
                  pins_stable[i] <= s3_r[i];
               end
            end
         end
      end
   endgenerate
endmodule : eip_pin_sync
`default_nettype wire

// [logic/eip_pkg.sv]
// constants and types for the external pin interrupt block
`default_nettype none
package eip_pkg;
   localparam int          EIP_NUM_PC     = 24;
   localparam int          EIP_NUM_EXT    = 2;
   localparam int          EIP_NUM_PINS   = EIP_NUM_PC + EIP_NUM_EXT;
   localparam int          EIP_ADDR_W     = 8;
   localparam int          EIP_DATA_W     = 32;
   // register byte offsets
   localparam logic [7:0]  ADDR_SENSE     = 8'h00;
   localparam logic [7:0]  ADDR_EXT_EN    = 8'h04;
   localparam logic [7:0]  ADDR_EXT_FLAG  = 8'h08;
   localparam logic [7:0]  ADDR_PC_EN     = 8'h0c;
   localparam logic [7:0]  ADDR_PC_FLAG   = 8'h10;
   localparam logic [7:0]  ADDR_MASK0     = 8'h14;
   localparam logic [7:0]  ADDR_MASK1     = 8'h18;
   localparam logic [7:0]  ADDR_MASK2     = 8'h1c;
   localparam logic [7:0]  ADDR_STATUS    = 8'h20;
   localparam logic [7:0]  ADDR_PC_LEVEL  = 8'h24;
   localparam logic [7:0]  ADDR_BOOT_CFG  = 8'h28;
   // sense field encodings
   localparam logic [1:0]  SENSE_LOW      = 2'h0;
   localparam logic [1:0]  SENSE_ANY      = 2'h1;
   localparam logic [1:0]  SENSE_FALL     = 2'h2;
   localparam logic [1:0]  SENSE_RISE     = 2'h3;
   // bus responses
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   // start-up timing
   localparam int          CLK_PERIOD_NS  = 40;
   localparam int          STARTUP_UNIT_NS = 320;
   localparam logic [15:0] STARTUP_UNIT_CYC =
      16'((STARTUP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] CNT_ONE        = 16'h0001;
   typedef enum logic [1:0] {
      ST_RUN   = 2'b01,
      ST_START = 2'b10
   } eip_state_type;
endpackage : eip_pkg
`default_nettype wire

// [sim/eip_controller_tb_top.sv]
// self-checking bench for the pin interrupt controller
`default_nettype none
`timescale 1ns/1ns
module eip_controller_tb_top
   import eip_pkg::*;
   ;
   localparam int         STS_V = 1;
   localparam int         CKS_V = 3;
   localparam int         START_CYC = ((CKS_V + 1) * 8) << STS_V;
   localparam int         PIN[3] = '{3, 10, 20};
   localparam int         OFS[3] = '{0, 8, 16};
   logic                  aclk, aresetn, awvalid, wvalid, bready, arvalid;
   logic                  rready, awready, wready, bvalid, arready, rvalid;
   logic                  io_run, pad0, pad1, wake, pc0_q, pc1_q, pc2_q;
   logic [EIP_ADDR_W-1:0] awaddr, araddr;
   logic [EIP_DATA_W-1:0] wdata, rdata;
   logic [1:0]            bresp, rresp, ext_q, ext_ack;
   logic [2:0]            pc_ack;
   logic [EIP_NUM_PC-1:0] pc_pads;
   int                    bad_count, compares;
   wire  [5:0]            reqs = {wake, pc2_q, pc1_q, pc0_q, ext_q};

   eip_pin_source eip_pin_source_i (.aclk(aclk), .pad0(pad0), .pad1(pad1),
      .pc_pads(pc_pads));
   eip_controller eip_controller_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_request_pin_0(pad0),
      .ext_request_pin_1(pad1), .pin_change_inputs(pc_pads),
      .io_clock_run(io_run), .ext_ack(ext_ack), .pc_ack(pc_ack),
      .startup_time_select(2'(STS_V)), .clock_source_select(4'(CKS_V)),
      .ext_request(ext_q), .pin_change_group0_request(pc0_q),
      .pin_change_group1_request(pc1_q), .pin_change_group2_request(pc2_q),
      .wake_request(wake));

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task automatic results;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results

   task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // outputs are levels, so look after a fixed settle time
   task automatic chk_req(input int n, input logic [5:0] e);
      repeat (n) @(posedge aclk);
      chk("requests", 32'(e), 32'(reqs));
   endtask : chk_req

   task automatic wr(input logic [7:0] a, logic [31:0] d, logic [1:0] er);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      chk("bresp", 32'(er), 32'(bresp));
   endtask : wr

   task automatic rd(input logic [7:0] a, logic [31:0] e, logic [1:0] er);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      chk("rdata", e, rdata);
      chk("rresp", 32'(er), 32'(rresp));
   endtask : rd

   task automatic s_regs;
      rd(ADDR_SENSE, 32'h0, RESP_OKAY);
      rd(ADDR_BOOT_CFG, 32'((STS_V << 4) | CKS_V), RESP_OKAY);
      wr(ADDR_BOOT_CFG, 32'hff, RESP_OKAY);
      rd(ADDR_BOOT_CFG, 32'((STS_V << 4) | CKS_V), RESP_OKAY);
      rd(ADDR_STATUS, 32'h3, RESP_OKAY);
      rd(ADDR_PC_LEVEL, 32'h00ffffff, RESP_OKAY);
      rd(8'h40, 32'h0, RESP_SLVERR);
      wr(8'h40, 32'h3, RESP_SLVERR);
   endtask : s_regs

   task automatic s_edges;
      wr(ADDR_SENSE, 32'h0e, RESP_OKAY);
      wr(ADDR_EXT_EN, 32'h3, RESP_OKAY);
      eip_pin_source_i.set_ext(0, 1'b0);
      chk_req(10, 6'h01);
      rd(ADDR_EXT_FLAG, 32'h1, RESP_OKAY);
      wr(ADDR_EXT_FLAG, 32'h1, RESP_OKAY);
      chk_req(10, 6'h00);
      eip_pin_source_i.set_ext(1, 1'b0);
      chk_req(10, 6'h00);
      eip_pin_source_i.set_ext(1, 1'b1);
      chk_req(10, 6'h02);
      @(posedge aclk);
      ext_ack <= 2'h2;
      @(posedge aclk);
      ext_ack <= 2'h0;
      chk_req(4, 6'h00);
      wr(ADDR_SENSE, 32'h0d, RESP_OKAY);
      eip_pin_source_i.set_ext(0, 1'b1);
      chk_req(10, 6'h01);
      wr(ADDR_EXT_FLAG, 32'h1, RESP_OKAY);
   endtask : s_edges

   task automatic s_level;
      wr(ADDR_SENSE, 32'h0, RESP_OKAY);
      wr(ADDR_EXT_EN, 32'h1, RESP_OKAY);
      eip_pin_source_i.set_ext(0, 1'b0);
      chk_req(30, 6'h01);
      rd(ADDR_EXT_FLAG, 32'h0, RESP_OKAY);
      io_run <= 1'b0;
      chk_req(6, 6'h21);
      io_run <= 1'b1;
      chk_req(10, 6'h00);
      rd(ADDR_STATUS, 32'h6, RESP_OKAY);
      chk_req(START_CYC, 6'h01);
      eip_pin_source_i.set_ext(0, 1'b1);
      chk_req(10, 6'h00);
   endtask : s_level

   task automatic s_stop;
      wr(ADDR_SENSE, 32'h08, RESP_OKAY);
      wr(ADDR_EXT_EN, 32'h2, RESP_OKAY);
      io_run <= 1'b0;
      eip_pin_source_i.set_ext(1, 1'b0);
      chk_req(12, 6'h00);
      io_run <= 1'b1;
      chk_req(10, 6'h02);
      wr(ADDR_EXT_FLAG, 32'h2, RESP_OKAY);
      eip_pin_source_i.set_ext(1, 1'b1);
   endtask : s_stop

   task automatic s_groups;
      wr(ADDR_PC_EN, 32'h7, RESP_OKAY);
      for (int g = 0; g < 3; g++) begin
         wr(ADDR_MASK0 + 8'(4 * g), 32'h1 << (PIN[g] - OFS[g]), RESP_OKAY);
         io_run <= 1'b0;
         eip_pin_source_i.flip_pc(24'h1 << (PIN[g] + 1));
         chk_req(10, 6'h00);
         eip_pin_source_i.flip_pc(24'h1 << PIN[g]);
         chk_req(10, 6'h20 | (6'h4 << g));
         io_run <= 1'b1;
         rd(ADDR_PC_FLAG, 32'h1 << g, RESP_OKAY);
         @(posedge aclk);
         pc_ack <= 3'(1 << g);
         @(posedge aclk);
         pc_ack <= 3'h0;
         chk_req(4, 6'h00);
      end
   endtask : s_groups

   initial begin
      aresetn   = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr    = '0;
      araddr    = '0;
      wdata     = '0;
      io_run    = 1'b1;
      ext_ack   = 2'h0;
      pc_ack    = 3'h0;
      bad_count = 0;
      compares  = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      chk_req(6, 6'h00);
      s_regs();
      s_edges();
      s_level();
      s_stop();
      s_groups();
      results();
   end

   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      results();
   end
endmodule : eip_controller_tb_top
`default_nettype wire

// [sim/eip_pin_source.sv]
// outside sources that drive the interrupt pads
`default_nettype none
`timescale 1ns/1ns
module eip_pin_source
   import eip_pkg::*;
(
   input  wire logic                  aclk,
   output var  logic                  pad0,
   output var  logic                  pad1,
   output var  logic [EIP_NUM_PC-1:0] pc_pads
);
   // idle high so nothing fires at reset release
   initial begin
      pad0    = 1'b1;
      pad1    = 1'b1;
      pc_pads = 24'hffffff;
   end
   // level held until the next call, far past one clock
   task automatic set_ext(input int idx, input logic v);
      @(posedge aclk);
      if (idx == 0) pad0 <= v;
      else pad1 <= v;
   endtask : set_ext
   // an output-driven level reaches the pad the same way
   task automatic flip_pc(input logic [EIP_NUM_PC-1:0] m);
      @(posedge aclk);
      pc_pads <= pc_pads ^ m;
   endtask : flip_pc
endmodule : eip_pin_source
`default_nettype wire
